/* hw/pin_sync2.sv */
`timescale 1ns/1ns
module pin_sync2 #(
   parameter int unsigned     WIDTH     = 8,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] pins_in,
   output logic      [WIDTH-1:0] pins_sync
);

   typedef struct packed {
      logic [WIDTH-1:0] first;
      logic [WIDTH-1:0] second;
   } sync_state_t;

   sync_state_t sync_reg;
   sync_state_t sync_next;

   // first stage is read only by the second stage
   always_comb begin
      sync_next.first  = pins_in;
      sync_next.second = sync_reg.first;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         sync_reg <= '{first: RESET_VAL, second: RESET_VAL};
      end else begin
         sync_reg <= sync_next;
      end
   end

   assign pins_sync = sync_reg.second;

endmodule // pin_sync2

/* hw/updown_counter4.sv */
`timescale 1ns/1ns
module updown_counter4
   import updown_pkg::*;
(
   input  wire logic                        clock,
   input  wire logic                        rst,
   input  wire logic                        count_up,
   input  wire logic                        count_down,
   input  wire logic                        load_n,
   input  wire logic [updown_pkg::COUNT_W-1:0] data_in,
   input  wire logic                        async_zero_input,
   output logic      [updown_pkg::COUNT_W-1:0] count,
   output logic                             borrow_out_n,
   output logic                             carry_out_n
);
   import updown_pkg::*;

   state_t           state_reg;
   state_t           state_next;
   logic [PIN_W-1:0] pins_raw;
   logic [PIN_W-1:0] pins_s;
   logic             up_s;
   logic             down_s;
   logic             load_n_s;
   logic             zero_s;
   logic [3:0]       data_s;
   logic             up_rise;
   logic             down_rise;

   function automatic logic [3:0] step(input logic [3:0] v,
                                       input logic       up);
      logic [3:0] r;
      r = up ? (v + COUNT_ONE) : (v - COUNT_ONE);
      return r;
   endfunction

   assign pins_raw = {count_up, count_down, load_n,
                      async_zero_input, data_in};

   pin_sync2 #(
      .WIDTH     (PIN_W),
      .RESET_VAL (PIN_IDLE)
   ) u_sync (
      .clock     (clock),
      .rst       (rst),
      .pins_in   (pins_raw),
      .pins_sync (pins_s)
   );

   assign up_s     = pins_s[PIN_UP];
   assign down_s   = pins_s[PIN_DOWN];
   assign load_n_s = pins_s[PIN_LOAD_N];
   assign zero_s   = pins_s[PIN_ZERO];
   assign data_s   = pins_s[PIN_DATA_L +: COUNT_W];

   assign up_rise   = up_s & ~state_reg.up_prev;
   assign down_rise = down_s & ~state_reg.down_prev;

   always_comb begin
      state_next           = state_reg;
      state_next.up_prev   = up_s;
      state_next.down_prev = down_s;
      if (zero_s) begin
         state_next.count = COUNT_ZERO;
      end else if (!load_n_s) begin
         state_next.count = data_s;
      end else if (up_rise && !down_rise) begin
         // wraps 15 -> 0 in 4-bit arithmetic
         state_next.count = step(state_reg.count, 1'b1);
      end else if (down_rise && !up_rise) begin
         // wraps 0 -> 15 in 4-bit arithmetic
         state_next.count = step(state_reg.count, 1'b0);
      end else begin
         // idle, or both edges at once, which the driver must avoid
         state_next.count = state_reg.count;
      end
      // low pulses let the next stage count on their rising edge
      state_next.borrow_n = ~((state_next.count == COUNT_ZERO)
                              & ~down_s);
      state_next.carry_n  = ~((state_next.count == COUNT_MAX)
                              & ~up_s);
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_reg <= STATE_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   assign count        = state_reg.count;
   assign borrow_out_n = state_reg.borrow_n;
   assign carry_out_n  = state_reg.carry_n;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   logic past_valid_reg;
   always_ff @(posedge clock) begin
      if (rst) begin
         past_valid_reg <= 1'b0;
      end else begin
         past_valid_reg <= 1'b1;
      end
   end

   clear_forces_zero_a: assert property (
      zero_s |=> count == COUNT_ZERO)
      else $error("count not zero after clear");

   // judged one cycle after the second clear sample, once zero has landed
   clear_beats_all_a: assert property (
      zero_s ##1 zero_s |=> count == COUNT_ZERO && $stable(count))
      else $error("count moved while clear held");

   load_follows_data_a: assert property (
      !zero_s && !load_n_s |=> count == $past(data_s))
      else $error("count does not follow data during load");

   load_blocks_count_a: assert property (
      (!zero_s && !load_n_s && (up_rise || down_rise))
      |=> count == $past(data_s))
      else $error("count edge acted during load");

   up_step_a: assert property (
      (!zero_s && load_n_s && up_rise && !down_rise)
      |=> count == step($past(count), 1'b1))
      else $error("up edge did not add one");

   down_step_a: assert property (
      (!zero_s && load_n_s && down_rise && !up_rise)
      |=> count == step($past(count), 1'b0))
      else $error("down edge did not subtract one");

   up_wrap_a: assert property (
      (!zero_s && load_n_s && up_rise && !down_rise
       && count == COUNT_MAX) |=> count == COUNT_ZERO)
      else $error("no wrap from 15 to 0");

   down_wrap_a: assert property (
      (!zero_s && load_n_s && down_rise && !up_rise
       && count == COUNT_ZERO) |=> count == COUNT_MAX)
      else $error("no wrap from 0 to 15");

   count_hold_a: assert property (
      (!zero_s && load_n_s && !up_rise && !down_rise) |=> $stable(count))
      else $error("count changed without cause");

   count_cause_a: assert property (
      (past_valid_reg && $changed(count))
      |-> $past(zero_s) || !$past(load_n_s)
          || $past(up_rise) || $past(down_rise))
      else $error("count changed with no edge, load or clear");

   borrow_level_a: assert property (
      past_valid_reg |->
      borrow_out_n == !(count == COUNT_ZERO && !$past(down_s)))
      else $error("borrow out wrong for count and down level");

   carry_level_a: assert property (
      past_valid_reg |->
      carry_out_n == !(count == COUNT_MAX && !$past(up_s)))
      else $error("carry out wrong for count and up level");

   carry_before_wrap_a: assert property (
      (!carry_out_n && !zero_s && load_n_s)
      ##1 (up_rise && !zero_s && load_n_s && !down_rise)
      |=> count == COUNT_ZERO && carry_out_n)
      else $error("carry pulse not followed by wrap to 0");

   load_thirteen_c: cover property (
      !zero_s && !load_n_s && data_s == 4'hd ##1 count == 4'hd);

   wrap_up_c: cover property (
      count == COUNT_MAX ##1 !carry_out_n ##[1:8] count == COUNT_ZERO);

   wrap_down_c: cover property (
      count == COUNT_ZERO ##1 !borrow_out_n ##[1:8] count == COUNT_MAX);

   clear_nonzero_c: cover property (
      count != COUNT_ZERO && zero_s ##1 count == COUNT_ZERO);

endmodule // updown_counter4

/* pkg/updown_pkg.sv */
package updown_pkg;

   localparam int unsigned COUNT_W    = 4;
   localparam logic [3:0]  COUNT_ZERO = 4'h0;
   localparam logic [3:0]  COUNT_ONE  = 4'h1;
   localparam logic [3:0]  COUNT_MAX  = 4'hf;

   // pin bundle fed through the synchroniser: up, down, load_n, clear, data
   localparam int unsigned PIN_W      = 8;
   localparam int unsigned PIN_UP     = 7;
   localparam int unsigned PIN_DOWN   = 6;
   localparam int unsigned PIN_LOAD_N = 5;
   localparam int unsigned PIN_ZERO   = 4;
   localparam int unsigned PIN_DATA_L = 0;
   // count inputs idle high, load idle high, clear idle low
   localparam logic [7:0]  PIN_IDLE   = 8'he0;

   localparam logic        IDLE_HIGH  = 1'b1;

   typedef struct packed {
      logic [3:0] count;
      logic       up_prev;
      logic       down_prev;
      logic       borrow_n;
      logic       carry_n;
   } state_t;

   localparam state_t STATE_RESET = '{
      count:     COUNT_ZERO,
      up_prev:   IDLE_HIGH,
      down_prev: IDLE_HIGH,
      borrow_n:  IDLE_HIGH,
      carry_n:   IDLE_HIGH
   };

endpackage

/* tb/pin_driver.sv */
`timescale 1ns/1ns
module pin_driver (
   input  wire logic clock,
   output logic      count_up,
   output logic      count_down
);
   initial begin
      count_up   = 1'b1;
      count_down = 1'b1;
   end
   // caller keeps the idle line high while the other moves
   // a preceding stage's carry and borrow would drive these pins
   task automatic set_level(input logic up_lvl, input logic dn_lvl);
      @(posedge clock);
      #1;
      count_up   = up_lvl;
      count_down = dn_lvl;
   endtask
endmodule // pin_driver

/* tb/testbench.sv */
`timescale 1ns/1ns
module testbench;
   import updown_pkg::*;
   logic               clock            = 1'b0;
   logic               rst              = 1'b1;
   logic               load_n           = 1'b1;
   logic               async_zero_input = 1'b0;
   logic [COUNT_W-1:0] data_in          = COUNT_ZERO;
   logic [COUNT_W-1:0] ref_count        = COUNT_ZERO;
   logic               up_old           = 1'b1;
   logic               dn_old           = 1'b1;
   logic               count_up;
   logic               count_down;
   logic [COUNT_W-1:0] count;
   logic               borrow_out_n;
   logic               carry_out_n;
   logic [5:0]         exp_q[$];
   event               look;
   int                 num_errors       = 0;
   int                 checks_done      = 0;
   int                 cycles           = 0;

   always #20 clock = ~clock;

   pin_driver drv (.clock(clock), .count_up(count_up),
                   .count_down(count_down));

   updown_counter4 dut (
      .clock(clock), .rst(rst), .count_up(count_up),
      .count_down(count_down), .load_n(load_n), .data_in(data_in),
      .async_zero_input(async_zero_input), .count(count),
      .borrow_out_n(borrow_out_n), .carry_out_n(carry_out_n));

   task automatic finish_test();
      $display("checks_done %0d num_errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic compare_count(input logic [3:0] e, input logic [3:0] s);
      checks_done++;
      if (s !== e) begin
         num_errors++;
         $display("[FAIL] count expected %h seen %h", e, s);
      end
   endtask

   task automatic compare_flag(input string n, input logic e, input logic s);
      checks_done++;
      if (s !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %b seen %b", n, e, s);
      end
   endtask

   always @(look) begin : monitor
      logic [5:0] note;
      note = exp_q.pop_front();
      compare_count(note[5:2], count);
      compare_flag("borrow_out_n", note[1], borrow_out_n);
      compare_flag("carry_out_n", note[0], carry_out_n);
   end

   // apply pins, update the reference, then look once settled
   task automatic step(input logic u, input logic d, input logic ld_n,
                       input logic clr, input logic [3:0] dat);
      drv.set_level(u, d);
      load_n           = ld_n;
      async_zero_input = clr;
      data_in          = dat;
      if (clr)
         ref_count = COUNT_ZERO;
      else if (!ld_n)
         ref_count = dat;
      else if (u && !up_old && d)
         ref_count = ref_count + COUNT_ONE;
      else if (d && !dn_old && u)
         ref_count = ref_count - COUNT_ONE;
      up_old = u;
      dn_old = d;
      repeat (4) @(posedge clock);
      #2;
      exp_q.push_back({ref_count, !(ref_count == COUNT_ZERO && !d),
                       !(ref_count == COUNT_MAX && !u)});
      -> look;
   endtask

   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         finish_test();
      end
   end

   initial begin : main
      logic [3:0] r;
      logic       nu;
      logic       nd;
      void'($urandom(38));
      repeat (16) @(posedge clock);
      #1 rst = 1'b0;
      #2 exp_q.push_back({COUNT_ZERO, 2'b11});
      -> look;
      step(1'b1, 1'b1, 1'b1, 1'b1, 4'h0);
      step(1'b0, 1'b1, 1'b1, 1'b1, 4'h7);
      step(1'b1, 1'b1, 1'b0, 1'b1, 4'h7);
      step(1'b0, 1'b1, 1'b0, 1'b0, 4'hd);
      step(1'b1, 1'b1, 1'b0, 1'b0, 4'hd);
      for (int i = 0; i < 6; i++)
         step(i[0], 1'b1, 1'b1, 1'b0, 4'h2);
      for (int i = 0; i < 2; i++)
         step(1'b1, i[0], 1'b1, 1'b0, 4'h2);
      step(1'b1, 1'b1, 1'b1, 1'b0, 4'h5);
      repeat (300) begin
         r = 4'($urandom_range(15, 0));
         nu = r[1] ? r[0] : 1'b1;
         nd = r[1] ? 1'b1 : r[0];
         // never let one count line rise while the other falls
         if ((!up_old && !nd) || (!dn_old && !nu)) begin
            nu = 1'b1;
            nd = 1'b1;
         end
         step(nu, nd,
              !(r[3:2] == 2'b11 && r[1]), r[3:2] == 2'b11 && !r[1],
              4'($urandom_range(15, 0)));
      end
      @(posedge clock);
      finish_test();
   end
endmodule // testbench
